// File: src/pmg_defs.svh
/*
 constants for the period measurement gate: register offsets, field
 positions, reset values, limits and timing counts.
 assumes a 100 MHz pclk and an apb slave with 32-bit data.
*/
`ifndef PMG_DEFS_SVH
`define PMG_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PMG_OFF_CTRL      12'h000
`define PMG_OFF_LOWER     12'h004
`define PMG_OFF_UPPER     12'h008
`define PMG_OFF_WINDOW    12'h00c
`define PMG_OFF_CYCLE     12'h010
`define PMG_OFF_PERIOD    12'h014
`define PMG_OFF_STATUS    12'h018
`define PMG_OFF_CMD       12'h01c

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define PMG_CTRL_GATE     0
`define PMG_CTRL_PINGATE  1
`define PMG_CTRL_FINE     2
`define PMG_CTRL_ISO      3
`define PMG_CTRL_OUT1_EN  4
`define PMG_CTRL_OUT1_SET 5
`define PMG_CTRL_OUT2_EN  6
`define PMG_CTRL_OUT2_SET 7
`define PMG_CTRL_FUNC_LO  8
`define PMG_CTRL_FUNC_HI  9
`define PMG_CTRL_RESET    32'h0000_0000

// ----------------------------------------------------------------
// command strobe fields (write one to act)
// ----------------------------------------------------------------
`define PMG_CMD_LOWER     0
`define PMG_CMD_UPPER     1
`define PMG_CMD_FUNC      2
`define PMG_CMD_WINDOW    3
`define PMG_CMD_ACK       4

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define PMG_ST_GATE       0
`define PMG_ST_PIN        1
`define PMG_ST_OUT1       3
`define PMG_ST_OUT2       4
`define PMG_ST_LOADERR    8
`define PMG_ST_PARAERR    9
`define PMG_ST_UNDER      16
`define PMG_ST_OVER       17
`define PMG_ST_DONE       18
`define PMG_ST_ISO        19

// ----------------------------------------------------------------
// limits
// ----------------------------------------------------------------
`define PMG_LOW_MAX_US    32'd119_999_999
`define PMG_HIGH_MAX_US   32'd120_000_000
`define PMG_LOW_MAX_FINE  32'd1_919_999_999
`define PMG_HIGH_MAX_FINE 32'd1_920_000_000
`define PMG_N_MAX         32'd12000
`define PMG_BASE_MS       32'd10
`define PMG_SPAN_MS       32'd120000
`define PMG_LOWER_RESET   32'h0000_0000
`define PMG_UPPER_RESET   32'd120_000_000
`define PMG_WINDOW_RESET  32'h0000_0001
`define PMG_CYCLE_RESET   32'h0000_000a

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMG_CLK_MHZ       100
`define PMG_REF_MHZ       16
`define PMG_BASE_TIME_MS  10
`define PMG_BASE_CYCLES   (`PMG_BASE_TIME_MS * 1000 * `PMG_CLK_MHZ)

`endif

// File: src/pmg_pkg.sv
/*
 types for the period measurement gate.
 assumes pmg_defs.svh provides the numeric constants.
*/
package pmg_pkg;

   typedef enum logic [1:0] {
      PMG_FN_PLAIN   = 2'b00,
      PMG_FN_OUTSIDE = 2'b01,
      PMG_FN_UNDER   = 2'b10,
      PMG_FN_OVER    = 2'b11
   } pmg_out_fn_e;

   typedef enum logic [1:0] {
      PMG_MS_IDLE = 2'b00,
      PMG_MS_WAIT = 2'b01,
      PMG_MS_RUN  = 2'b10
   } pmg_meas_e;

endpackage

// File: src/pmg_period_measure.sv
/*
 period measurement gate: times counting-signal rising edges against a
 16 MHz reference derived from pclk, averages over the update window,
 checks limits, and gates measurement by program and pin gates.
 assumes an apb master on pclk, and synchronous pins and strobes.
*/
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "pmg_defs.svh"

module pmg_period_measure (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // field pins
   input  wire logic        count_in,
   input  wire logic        gate_input_pin,
   input  wire logic        input_instant,
   output logic             output_one,
   output logic             output_two
);

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic        acc;
   logic        wr;
   logic        known;
   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   assign pready = 1'b1;
   always_comb begin
      case (paddr)
         `PMG_OFF_CTRL, `PMG_OFF_LOWER, `PMG_OFF_UPPER, `PMG_OFF_WINDOW,
         `PMG_OFF_CYCLE, `PMG_OFF_PERIOD, `PMG_OFF_STATUS,
         `PMG_OFF_CMD: known = 1'b1;
         default:      known = 1'b0;
      endcase
   end
   assign pslverr = acc & ~known;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic win_ok(input logic [31:0] n,
                                   input logic        iso,
                                   input logic [31:0] cyc_ms);
      logic [31:0] lo;
      logic [31:0] hi;
      lo = 32'd1;
      hi = `PMG_N_MAX;
      if (iso) begin
         if (cyc_ms == 32'd0) begin
            lo = 32'd1;
            hi = 32'd0;
         end else if (cyc_ms < `PMG_BASE_MS) begin
            lo = `PMG_BASE_MS / cyc_ms + 32'd1;
         end else begin
            hi = `PMG_SPAN_MS / cyc_ms;
         end
      end
      win_ok = (n >= lo) && (n <= hi);
   endfunction

   function automatic logic bound_ok(input logic [31:0] lo,
                                     input logic [31:0] hi,
                                     input logic        fine);
      logic [31:0] lmax;
      logic [31:0] hmax;
      lmax = fine ? `PMG_LOW_MAX_FINE : `PMG_LOW_MAX_US;
      hmax = fine ? `PMG_HIGH_MAX_FINE : `PMG_HIGH_MAX_US;
      bound_ok = (lo <= lmax) && (hi > lo) && (hi <= hmax);
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl, next_ctrl;
   logic [31:0] lower_period_bound, next_lower;
   logic [31:0] upper_period_bound, next_upper;
   logic [31:0] win_req, next_win_req;
   logic [31:0] win_n, next_win_n;
   logic [31:0] bus_cycle_period, next_cycle;
   logic [1:0]  out1_fn, next_out1_fn;
   logic        load_err, next_load_err;
   logic        para_err, next_para_err;
   logic        iso_on, next_iso_on;
   logic        done_flag, next_done_flag;
   logic        under_flag, next_under_flag;
   logic        over_flag, next_over_flag;
   logic [31:0] cmd;
   logic        lower_bound_load;
   logic        upper_bound_load;
   logic        out1_function_change;
   logic        window_length_change;
   logic        ack;
   logic        cmp_pulse;
   logic        cmp_under;
   logic        cmp_over;

   assign cmd = (wr && paddr == `PMG_OFF_CMD) ? pwdata : 32'h0000_0000;
   assign lower_bound_load     = cmd[`PMG_CMD_LOWER];
   assign upper_bound_load     = cmd[`PMG_CMD_UPPER];
   assign out1_function_change = cmd[`PMG_CMD_FUNC];
   assign window_length_change = cmd[`PMG_CMD_WINDOW];
   assign ack                  = cmd[`PMG_CMD_ACK];

   always_comb begin
      next_ctrl       = ctrl;
      next_lower      = lower_period_bound;
      next_upper      = upper_period_bound;
      next_win_req    = win_req;
      next_win_n      = win_n;
      next_cycle      = bus_cycle_period;
      next_out1_fn    = out1_fn;
      next_load_err   = load_err;
      next_para_err   = para_err;
      next_done_flag  = done_flag;
      next_under_flag = under_flag;
      next_over_flag  = over_flag;
      if (wr) begin
         case (paddr)
            `PMG_OFF_CTRL:   next_ctrl    = pwdata;
            `PMG_OFF_WINDOW: next_win_req = pwdata;
            `PMG_OFF_CYCLE:  next_cycle   = pwdata;
            default:         next_ctrl    = ctrl;
         endcase
      end
      // staged values take effect only by their own command
      if (lower_bound_load) begin
         if (bound_ok(pwdata, upper_period_bound, ctrl[`PMG_CTRL_FINE]))
            next_lower = pwdata;
         next_load_err = ~bound_ok(pwdata, upper_period_bound,
                                   ctrl[`PMG_CTRL_FINE]);
      end
      if (upper_bound_load) begin
         if (bound_ok(lower_period_bound, pwdata, ctrl[`PMG_CTRL_FINE]))
            next_upper = pwdata;
         next_load_err = ~bound_ok(lower_period_bound, pwdata,
                                   ctrl[`PMG_CTRL_FINE]);
      end
      if (out1_function_change)
         next_out1_fn = ctrl[`PMG_CTRL_FUNC_HI:`PMG_CTRL_FUNC_LO];
      if (window_length_change) begin
         if (win_ok(win_req, ctrl[`PMG_CTRL_ISO], bus_cycle_period))
            next_win_n = win_req;
         next_para_err = ~win_ok(win_req, ctrl[`PMG_CTRL_ISO],
                                 bus_cycle_period);
      end
      // an illegal window under an isochronous request is flagged at once
      if (next_ctrl[`PMG_CTRL_ISO]
          && !win_ok(next_win_n, 1'b1, next_cycle))
         next_para_err = 1'b1;
      // sticky flags: a new event wins over the acknowledge
      if (ack) begin
         next_done_flag  = 1'b0;
         next_under_flag = 1'b0;
         next_over_flag  = 1'b0;
      end
      if (cmp_pulse) begin
         next_done_flag = 1'b1;
         if (cmp_under)
            next_under_flag = 1'b1;
         if (cmp_over)
            next_over_flag = 1'b1;
      end
   end

   // isochronous operation only when requested and the window is legal
   assign next_iso_on = ctrl[`PMG_CTRL_ISO] & ~para_err
                        & win_ok(win_n, 1'b1, bus_cycle_period);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl               <= `PMG_CTRL_RESET;
         lower_period_bound <= `PMG_LOWER_RESET;
         upper_period_bound <= `PMG_UPPER_RESET;
         win_req            <= `PMG_WINDOW_RESET;
         win_n              <= `PMG_WINDOW_RESET;
         bus_cycle_period   <= `PMG_CYCLE_RESET;
         out1_fn            <= 2'b00;
         load_err           <= 1'b0;
         para_err           <= 1'b0;
         iso_on             <= 1'b0;
         done_flag          <= 1'b0;
         under_flag         <= 1'b0;
         over_flag          <= 1'b0;
      end else begin
         ctrl               <= next_ctrl;
         lower_period_bound <= next_lower;
         upper_period_bound <= next_upper;
         win_req            <= next_win_req;
         win_n              <= next_win_n;
         bus_cycle_period   <= next_cycle;
         out1_fn            <= next_out1_fn;
         load_err           <= next_load_err;
         para_err           <= next_para_err;
         iso_on             <= next_iso_on;
         done_flag          <= next_done_flag;
         under_flag         <= next_under_flag;
         over_flag          <= next_over_flag;
      end
   end

   // ----------------------------------------------------------------
   // gates
   // ----------------------------------------------------------------
   logic program_gate_request;
   logic program_gate, next_program_gate;
   logic req_d, pin_d;
   logic pin_gate, next_pin_gate;
   logic gate_raw;
   logic internal_gate_state, next_gate_state;

   assign program_gate_request = ctrl[`PMG_CTRL_GATE];

   always_comb begin
      next_program_gate = program_gate;
      if (!program_gate_request)
         next_program_gate = 1'b0;
      else if (!req_d)
         next_program_gate = 1'b1;
      next_pin_gate = pin_gate;
      if (gate_input_pin && !pin_d)
         next_pin_gate = 1'b1;
      else if (!gate_input_pin && pin_d)
         next_pin_gate = 1'b0;
      // pin gate only counts when the pin is assigned to it
      gate_raw = program_gate & (pin_gate | ~ctrl[`PMG_CTRL_PINGATE]);
      // isochronous changes wait for the next input instant
      next_gate_state = internal_gate_state;
      if (!iso_on || input_instant)
         next_gate_state = gate_raw;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_gate        <= 1'b0;
         req_d               <= 1'b0;
         pin_d               <= 1'b0;
         pin_gate            <= 1'b0;
         internal_gate_state <= 1'b0;
      end else begin
         program_gate        <= next_program_gate;
         req_d               <= program_gate_request;
         pin_d               <= gate_input_pin;
         pin_gate            <= next_pin_gate;
         internal_gate_state <= next_gate_state;
      end
   end

   // ----------------------------------------------------------------
   // measurement
   // ----------------------------------------------------------------
   logic [4:0]  frac, next_frac;
   logic [5:0]  ref_add;
   logic        ref_tick;
   logic [31:0] ticks, next_ticks;
   logic [31:0] span, next_span;
   logic [31:0] edges, next_edges;
   logic [31:0] base_cnt, next_base_cnt;
   logic [31:0] win_cnt, next_win_cnt;
   logic        win_end;
   logic        cnt_d;
   logic [31:0] period, next_period;
   logic [63:0] avg;
   logic [31:0] scaled;
   pmg_pkg::pmg_meas_e mstate, next_mstate;

   // 16 MHz reference as a fractional tick of 100 MHz
   assign ref_add  = {1'b0, frac} + 6'h04;
   assign ref_tick = ref_add >= 6'h19;
   assign win_end  = iso_on
      ? (input_instant && win_cnt + 32'd1 >= win_n)
      : (base_cnt == `PMG_BASE_CYCLES - 1 && win_cnt + 32'd1 >= win_n);
   assign avg      = (edges == 32'd0) ? 64'h0 : {32'h0, span} / {32'h0, edges};
   // ticks are 1/16 us; coarse mode drops four bits
   assign scaled   = ctrl[`PMG_CTRL_FINE] ? avg[31:0] : {4'h0, avg[31:4]};
   assign cmp_under = scaled < lower_period_bound;
   assign cmp_over  = scaled > upper_period_bound;

   always_comb begin
      next_frac     = ref_tick ? ref_add[4:0] - 5'h19 : ref_add[4:0];
      next_mstate   = mstate;
      next_ticks    = ticks;
      next_span     = span;
      next_edges    = edges;
      next_base_cnt = base_cnt;
      next_win_cnt  = win_cnt;
      next_period   = period;
      cmp_pulse     = 1'b0;
      if (base_cnt == `PMG_BASE_CYCLES - 1)
         next_base_cnt = 32'd0;
      else
         next_base_cnt = base_cnt + 32'd1;
      if (win_end)
         next_win_cnt = 32'd0;
      else if (iso_on ? input_instant : base_cnt == `PMG_BASE_CYCLES - 1)
         next_win_cnt = win_cnt + 32'd1;
      if (ref_tick)
         next_ticks = ticks + 32'd1;
      case (mstate)
         pmg_pkg::PMG_MS_IDLE: begin
            if (internal_gate_state)
               next_mstate = pmg_pkg::PMG_MS_WAIT;
         end
         pmg_pkg::PMG_MS_WAIT: begin
            if (!internal_gate_state)
               next_mstate = pmg_pkg::PMG_MS_IDLE;
            else if (count_in && !cnt_d) begin
               next_ticks  = {31'h0, ref_tick};
               next_span   = 32'd0;
               next_edges  = 32'd0;
               next_mstate = pmg_pkg::PMG_MS_RUN;
            end
         end
         pmg_pkg::PMG_MS_RUN: begin
            if (count_in && !cnt_d) begin
               next_span  = span + ticks;
               next_edges = edges + 32'd1;
               next_ticks = {31'h0, ref_tick};
            end
            if (win_end && edges != 32'd0) begin
               next_period = scaled;
               cmp_pulse   = 1'b1;
               next_span   = 32'd0;
               next_edges  = 32'd0;
            end
            if (!internal_gate_state)
               next_mstate = pmg_pkg::PMG_MS_IDLE;
         end
         default: next_mstate = pmg_pkg::PMG_MS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frac     <= 5'h00;
         mstate   <= pmg_pkg::PMG_MS_IDLE;
         ticks    <= 32'h0;
         span     <= 32'h0;
         edges    <= 32'h0;
         base_cnt <= 32'h0;
         win_cnt  <= 32'h0;
         cnt_d    <= 1'b0;
         period   <= 32'h0;
      end else begin
         frac     <= next_frac;
         mstate   <= next_mstate;
         ticks    <= next_ticks;
         span     <= next_span;
         edges    <= next_edges;
         base_cnt <= next_base_cnt;
         win_cnt  <= next_win_cnt;
         cnt_d    <= count_in;
         period   <= next_period;
      end
   end

   // ----------------------------------------------------------------
   // outputs and read data
   // ----------------------------------------------------------------
   logic out1_lim, next_out1, next_out2;
   logic [31:0] status, next_prdata;

   always_comb begin
      case (pmg_pkg::pmg_out_fn_e'(out1_fn))
         pmg_pkg::PMG_FN_OUTSIDE: out1_lim = under_flag | over_flag;
         pmg_pkg::PMG_FN_UNDER:   out1_lim = under_flag;
         pmg_pkg::PMG_FN_OVER:    out1_lim = over_flag;
         default:                 out1_lim = ctrl[`PMG_CTRL_OUT1_SET];
      endcase
   end
   assign next_out1 = ctrl[`PMG_CTRL_OUT1_EN] & out1_lim;
   assign next_out2 = ctrl[`PMG_CTRL_OUT2_EN] & ctrl[`PMG_CTRL_OUT2_SET];

   always_comb begin
      status = 32'h0;
      status[`PMG_ST_GATE]    = internal_gate_state;
      status[`PMG_ST_PIN]     = gate_input_pin;
      status[`PMG_ST_OUT1]    = output_one;
      status[`PMG_ST_OUT2]    = output_two;
      status[`PMG_ST_LOADERR] = load_err;
      status[`PMG_ST_PARAERR] = para_err;
      status[`PMG_ST_UNDER]   = under_flag;
      status[`PMG_ST_OVER]    = over_flag;
      status[`PMG_ST_DONE]    = done_flag;
      status[`PMG_ST_ISO]     = iso_on;
      case (paddr)
         `PMG_OFF_CTRL:   next_prdata = ctrl;
         `PMG_OFF_LOWER:  next_prdata = lower_period_bound;
         `PMG_OFF_UPPER:  next_prdata = upper_period_bound;
         `PMG_OFF_WINDOW: next_prdata = win_n;
         `PMG_OFF_CYCLE:  next_prdata = bus_cycle_period;
         `PMG_OFF_PERIOD: next_prdata = period;
         `PMG_OFF_STATUS: next_prdata = status;
         default:         next_prdata = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_one <= 1'b0;
         output_two <= 1'b0;
         prdata     <= 32'h0;
      end else begin
         output_one <= next_out1;
         output_two <= next_out2;
         prdata     <= next_prdata;
      end
   end

endmodule

// File: tb/pmg_period_measure_props.sv
/*
 checker for the bus ports and the output_two port of the period measurement gate; output_one is only covered.
 assumes it is bound to pmg_period_measure on pclk and presetn.
*/
`timescale 1ns/1ps
module pmg_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // field pins
   input wire logic        count_in,
   input wire logic        gate_input_pin,
   input wire logic        input_instant,
   input wire logic        output_one,
   input wire logic        output_two
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   logic bad;
   logic wr_ctrl;
   assign acc = psel && penable;
   assign bad = paddr > 12'h01c || paddr[1:0] != 2'h0;
   assign wr_ctrl = acc && pwrite && paddr == 12'h000;
   AST_READY:
   assert property (acc |-> pready) else $error("pready low");
   AST_ERR_MAP:
   assert property (acc && bad |-> pslverr) else $error("no error");
   AST_ERR_OK:
   assert property (acc && !bad |-> !pslverr) else $error("false error");
   AST_ERR_IDLE:
   assert property (!psel |-> !pslverr) else $error("error when idle");
   AST_ERR_SETUP:
   assert property (psel && !penable |-> !pslverr) else $error("setup error");
   AST_RD_UNMAP:
   assert property (acc && !pwrite && bad |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_OUT2_CAUSE:
   assert property ($changed(output_two) |-> $past(wr_ctrl, 1)
      || $past(wr_ctrl, 2)) else $error("output two moved alone");
   AST_OUT2_HOLD:
   assert property (!wr_ctrl [*4] |=> $stable(output_two))
      else $error("output two unstable");
   COV_ERR: cover property (acc && pslverr);
   COV_OUT2: cover property ($rose(output_two));
   COV_OUT1: cover property ($rose(output_one));
endmodule
bind pmg_period_measure pmg_props u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .count_in(count_in), .gate_input_pin(gate_input_pin),
   .input_instant(input_instant), .output_one(output_one),
   .output_two(output_two));

// File: tb/pmg_field_model.sv
/*
 field side model: counting signal of fixed period and bus cycle marks.
 assumes pclk at 100 MHz; counting stops while en is low.
*/
`timescale 1ns/1ps
module pmg_field_model #(parameter int CNT = 400, parameter int INST = 2000) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic en,
   // field pins
   output logic     count_in,
   output logic     input_instant
);
   int c;
   int i;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c <= 0;
         i <= 0;
         count_in <= 1'b0;
         input_instant <= 1'b0;
      end else begin
         i <= (i == INST - 1) ? 0 : i + 1;
         input_instant <= (i == INST - 1);
         c <= (en && c != CNT - 1) ? c + 1 : 0;
         count_in <= en && (c < CNT / 2);
      end
   end
endmodule

// File: tb/tb_top.sv
/*
 self-checking bench: apb register tests, gates, outputs, measurement.
 assumes the design answers apb with pready and registered read data.
*/
`timescale 1ns/1ps
`include "pmg_defs.svh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic count_in, pin, instant, out1, out2, en;
   int fail_count, check_count;
   pmg_period_measure u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_in(count_in), .gate_input_pin(pin),
      .input_instant(instant), .output_one(out1), .output_two(out2));
   pmg_field_model u_field (.pclk(pclk), .presetn(presetn), .en(en),
      .count_in(count_in), .input_instant(instant));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r & m, e);
   endtask
   task automatic give_verdict;
      if (fail_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      give_verdict;
   end
   initial begin
      logic [31:0] r;
      {presetn, psel, penable, pwrite, paddr, pwdata, pin, en} = '0;
      fail_count = 0;
      check_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rc(`PMG_OFF_UPPER, '1, 32'd120_000_000);
      rc(`PMG_OFF_WINDOW, '1, 32'h1);
      rc(12'h020, '1, 32'h0);
      wr(`PMG_OFF_CMD, 32'h0727_0e02);
      rc(`PMG_OFF_UPPER, '1, 32'd120_000_000);
      rc(`PMG_OFF_STATUS, 32'h100, 32'h100);
      wr(`PMG_OFF_CMD, 32'h10);
      wr(`PMG_OFF_CTRL, 32'h4);
      wr(`PMG_OFF_CMD, 32'h0727_0e02);
      rc(`PMG_OFF_UPPER, '1, 32'h0727_0e02);
      rc(`PMG_OFF_STATUS, 32'h100, 32'h0);
      wr(`PMG_OFF_CMD, 32'h7270_e002);
      rc(`PMG_OFF_STATUS, 32'h100, 32'h100);
      wr(`PMG_OFF_CTRL, 32'h5);
      @(posedge pclk);
      rc(`PMG_OFF_STATUS, 32'h1, 32'h1);
      wr(`PMG_OFF_CTRL, 32'h7);
      rc(`PMG_OFF_STATUS, 32'h3, 32'h0);
      @(posedge pclk) pin <= 1'b1;
      @(posedge pclk);
      rc(`PMG_OFF_STATUS, 32'h3, 32'h3);
      @(posedge pclk) pin <= 1'b0;
      @(posedge pclk);
      rc(`PMG_OFF_STATUS, 32'h3, 32'h0);
      wr(`PMG_OFF_CTRL, 32'h6);
      @(posedge pclk) pin <= 1'b1;
      wr(`PMG_OFF_CTRL, 32'h7);
      @(posedge pclk);
      rc(`PMG_OFF_STATUS, 32'h1, 32'h1);
      wr(`PMG_OFF_CTRL, 32'hf4);
      rc(`PMG_OFF_STATUS, 32'h18, 32'h18);
      chk({30'h0, out1, out2}, 32'h3);
      wr(`PMG_OFF_CYCLE, 32'h5);
      wr(`PMG_OFF_WINDOW, 32'h1);
      wr(`PMG_OFF_CMD, 32'h8);
      wr(`PMG_OFF_CTRL, 32'hc);
      rc(`PMG_OFF_STATUS, 32'h8_0200, 32'h200);
      wr(`PMG_OFF_CTRL, 32'h4);
      wr(`PMG_OFF_CYCLE, 32'ha);
      wr(`PMG_OFF_CMD, 32'h8);
      wr(`PMG_OFF_CMD, 32'h10);
      wr(`PMG_OFF_CMD, 32'h101);
      wr(`PMG_OFF_CTRL, 32'h21c);
      wr(`PMG_OFF_CMD, 32'h4);
      en <= 1'b1;
      wr(`PMG_OFF_CTRL, 32'h21d);
      rc(`PMG_OFF_STATUS, 32'h8_0000, 32'h8_0000);
      r = 32'h0;
      for (int k = 0; k < 2000 && r[`PMG_ST_DONE] !== 1'b1; k++)
         apb(1'b0, `PMG_OFF_STATUS, 32'h0, r);
      rc(`PMG_OFF_PERIOD, '1, 32'd64);
      rc(`PMG_OFF_STATUS, 32'h1_0000, 32'h1_0000);
      rc(`PMG_OFF_WINDOW, '1, 32'h1);
      chk({31'h0, out1}, 32'h1);
      give_verdict;
   end
endmodule
